// ==== hscaler.sv ====
// horizontal scaler: integer prescale pick, then 6-bit phase interpolation
// assumes pixel source and sink on mclk; sink may stall via out_ready
`default_nettype none
`timescale 1ns/10ps

module hscaler
	import scaler_pkg::*;
#(
	parameter int W = scaler_pkg::PIX_W
) (
	// clock and reset
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic             clr,
	// scale setting
	input  wire scaler_pkg::scale_cfg_s scl,
	// input pixels
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [W-1:0]     in_data,
	// output pixels
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [W-1:0]          out_data
);
	import scaler_pkg::*;

	logic [PSC_W-1:0]   pre_cnt_reg;
	logic [PHASE_W-1:0] phase_reg;
	logic [W-1:0]       prev_reg;
	logic [W-1:0]       cur_reg;
	logic [1:0]         fill_reg;
	logic               out_valid_reg;
	logic [W-1:0]       out_data_reg;
	logic               pending;
	logic               emit;
	logic               pick;
	logic signed [W:0]  diff;
	logic signed [W+FRAC_W+1:0] prod;
	logic [W:0]         interp;

	// an output is owed while the phase still lies inside the current pair
	assign pending  = fill_reg[1] && (phase_reg < PHASE_ONE);
	assign emit     = pending && (!out_valid_reg || out_ready);
	assign pick     = (pre_cnt_reg == '0);
	// dropped prescale samples stall the source only while clr is high
	assign in_ready = !clr && (!pick || !pending);
	assign diff     = $signed({1'b0, cur_reg}) - $signed({1'b0, prev_reg});
	assign prod     = diff * $signed({1'b0, phase_reg[9:10-FRAC_W]});
	assign interp   = {1'b0, prev_reg} + prod[W+FRAC_W:FRAC_W];

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pre_cnt_reg <= '0;
		end else if (clr) begin
			pre_cnt_reg <= '0;
		end else if (in_valid && in_ready) begin
			if (pre_cnt_reg + 1'b1 >= scl.integer_prescale_factor)
				pre_cnt_reg <= '0;
			else
				pre_cnt_reg <= pre_cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			phase_reg <= '0;
			prev_reg  <= '0;
			cur_reg   <= '0;
			fill_reg  <= '0;
		end else if (clr) begin
			phase_reg <= '0;
			fill_reg  <= '0;
		end else if (emit) begin
			phase_reg <= phase_reg + PHASE_W'(scl.fine_scale_increment);
		end else if (in_valid && in_ready && pick) begin
			prev_reg <= cur_reg;
			cur_reg  <= in_data;
			fill_reg <= {fill_reg[0], 1'b1};
			if (fill_reg[1])
				phase_reg <= phase_reg - PHASE_ONE;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			out_valid_reg <= 1'b0;
			out_data_reg  <= '0;
		end else if (emit) begin
			out_valid_reg <= 1'b1;
			out_data_reg  <= interp[W-1:0];
		end else if (out_ready || clr) begin
			out_valid_reg <= 1'b0;
		end
	end

	assign out_valid = out_valid_reg;
	assign out_data  = out_data_reg;

	chk_phase_step: assert property (@(posedge mclk) disable iff (rst)
		emit && !clr |=> phase_reg ==
			$past(phase_reg) + PHASE_W'($past(scl.fine_scale_increment)))
		else $error("phase did not advance by the fine increment");

	chk_prescale_drop: assert property (@(posedge mclk) disable iff (rst)
		in_valid && in_ready && !pick && !emit |=> $stable(cur_reg))
		else $error("prescaler kept a dropped sample");

endmodule : hscaler

`default_nettype wire

// ==== scaler_pkg.sv ====
// constants, types and register map of the scaler task/field control block
// assumes a 32-bit AXI4-Lite register bus and a single 20 MHz clock
`default_nettype none

package scaler_pkg;

	localparam int          ADDR_W       = 8;
	localparam int          PIX_W        = 8;

	// register byte offsets
	localparam logic [7:0]  OFF_CTRL     = 8'h00;
	localparam logic [7:0]  OFF_CFG_A    = 8'h04;
	localparam logic [7:0]  OFF_CFG_B    = 8'h08;
	localparam logic [7:0]  OFF_SCL_A    = 8'h0c;
	localparam logic [7:0]  OFF_SCL_B    = 8'h10;
	localparam logic [7:0]  OFF_STAT     = 8'h14;

	// control register fields
	localparam int          CTRL_EN_A    = 0;
	localparam int          CTRL_EN_B    = 1;
	localparam int          CTRL_SRST    = 2;
	localparam int          CTRL_GPA_LSB = 3;
	localparam int          CTRL_GPB_LSB = 5;

	// reset values; soft reset bit is active low, so it resets to 1
	localparam logic [31:0] CTRL_RST     = 32'h0000_0004;
	localparam logic [31:0] CFG_RST      = 32'h0000_0000;
	localparam logic [31:0] SCL_RST      = 32'h0400_0001;

	// scale register fields
	localparam int          PSC_LSB      = 0;
	localparam int          PSC_W        = 6;
	localparam int          INC_LSB      = 16;
	localparam int          INC_W        = 13;

	// fine scaler phase: one input pixel is 1024 phase units
	localparam int          PHASE_W      = 14;
	localparam logic [13:0] PHASE_ONE    = 14'h0400;
	localparam int          FRAC_W       = 6;

	localparam logic [2:0]  SKIP_LAST    = 3'h1;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	typedef enum logic [1:0] {
		START_NOW,
		START_VSYNC,
		START_FIELD0,
		START_FIELD1
	} start_e;

	typedef enum logic [1:0] {
		GP_LOW,
		GP_FIELD,
		GP_TASK,
		GP_ACTIVE
	} gp_sel_e;

	// low byte of a task configuration register
	typedef struct packed {
		logic       code_mark_invert;
		logic       output_field_id_select;
		logic [2:0] field_skip_count;
		logic       task_repeat;
		start_e     start_condition_select;
	} task_cfg_s;

	typedef struct packed {
		logic [INC_W-1:0] fine_scale_increment;
		logic [PSC_W-1:0] integer_prescale_factor;
	} scale_cfg_s;

endpackage : scaler_pkg

`default_nettype wire

// ==== scaler_sink_model.sv ====
// pixel sink standing in for the back-end capture side
// assumes pixels arrive on mclk with a valid/ready handshake
`timescale 1ns/10ps
`default_nettype none

module scaler_sink_model (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// pixel stream
	input  wire logic       pix_out_valid,
	input  wire logic [7:0] pix_out_data,
	output logic            pix_out_ready
);
	int beats;
	// first accepted pixel, kept for the bench to compare
	logic [7:0] first_data;
	logic       got_first;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			first_data <= 8'h00;
			got_first  <= 1'b0;
		end else if (pix_out_valid && pix_out_ready && !got_first) begin
			first_data <= pix_out_data;
			got_first  <= 1'b1;
		end
	end

	// stalls every other cycle so the scaler must hold its output
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pix_out_ready <= 1'b0;
			beats         <= 0;
		end else begin
			pix_out_ready <= ~pix_out_ready;
			if (pix_out_valid && pix_out_ready)
				beats <= beats + 1;
		end
	end
endmodule : scaler_sink_model

`default_nettype wire

// ==== scaler_task_field_control.sv ====
// scaler task sequencer, output field marking and horizontal scaler
// assumes AXI4-Lite master on mclk; vsync and field id come from pins
//
// Added by the designer: the address map and register access over AXI4-Lite.
`default_nettype none
`timescale 1ns/10ps

module scaler_task_field_control
	import scaler_pkg::*;
(
	// clock and reset
	input  wire logic                 mclk,
	input  wire logic                 rst,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// video timing pins
	input  wire logic                 vsync_pin,
	input  wire logic                 field_identity_pin,
	// acquisition window events
	input  wire logic                 window_reached,
	input  wire logic                 task_done,
	// pixel stream
	input  wire logic                 pix_in_valid,
	output logic                      pix_in_ready,
	input  wire logic [PIX_W-1:0]     pix_in_data,
	output logic                      pix_out_valid,
	input  wire logic                 pix_out_ready,
	output logic [PIX_W-1:0]          pix_out_data,
	// field and task marking
	output logic                      sav_eav_d6,
	output logic                      sav_eav_d7,
	output logic                      gp_output_pin_a,
	output logic                      gp_output_pin_b,
	output logic                      task_active,
	output logic                      active_task_b
);
	import scaler_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_TRIG,
		ST_SKIP,
		ST_WIN,
		ST_RUN
	} task_state_e;

	function automatic logic [31:0] apply_wstrb(input logic [31:0] old,
		input logic [31:0] val, input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i])
				res[i*8 +: 8] = val[i*8 +: 8];
		end
		return res;
	endfunction : apply_wstrb

	function automatic logic reg_known(input logic [ADDR_W-1:0] a);
		return a == OFF_CTRL || a == OFF_CFG_A || a == OFF_CFG_B ||
			a == OFF_SCL_A || a == OFF_SCL_B || a == OFF_STAT;
	endfunction : reg_known

	function automatic logic gp_pick(input gp_sel_e sel, input logic field_identity,
		input logic mark, input logic run);
		unique case (sel)
			GP_LOW:    return 1'b0;
			GP_FIELD:  return field_identity;
			GP_TASK:   return mark;
			GP_ACTIVE: return run;
		endcase
	endfunction : gp_pick

	logic [31:0]       ctrl_reg;
	logic [31:0]       cfg_a_reg;
	logic [31:0]       cfg_b_reg;
	logic [31:0]       scl_a_reg;
	logic [31:0]       scl_b_reg;
	logic              aw_held_reg;
	logic              w_held_reg;
	logic [ADDR_W-1:0] aw_addr_reg;
	logic [31:0]       w_data_reg;
	logic [3:0]        w_strb_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic              rvalid_reg;
	logic [31:0]       rdata_reg;
	logic [1:0]        rresp_reg;
	logic              wr_fire;
	logic [31:0]       stat_word;

	logic [2:0]        vs_sync_reg;
	logic [1:0]        fid_sync_reg;
	logic              vs_rise;
	logic              field_identity;

	task_state_e       state_reg;
	logic              active_b_reg;
	logic              repeated_reg;
	logic [2:0]        skip_reg;
	logic [1:0]        tog_reg;
	logic              d6_reg;
	logic              d7_reg;
	logic              gpa_reg;
	logic              gpb_reg;

	logic              en_a;
	logic              en_b;
	logic              soft_run;
	logic              other_en;
	logic              cur_en;
	logic              trig_ok;
	logic              running;
	logic              d6_next;
	gp_sel_e           gp_sel_a;
	gp_sel_e           gp_sel_b;
	task_cfg_s         cur_cfg;
	scale_cfg_s        cur_scl;

	assign en_a     = ctrl_reg[CTRL_EN_A];
	assign en_b     = ctrl_reg[CTRL_EN_B];
	assign soft_run = ctrl_reg[CTRL_SRST];
	assign gp_sel_a = gp_sel_e'(ctrl_reg[CTRL_GPA_LSB +: 2]);
	assign gp_sel_b = gp_sel_e'(ctrl_reg[CTRL_GPB_LSB +: 2]);
	assign cur_cfg  = active_b_reg ? task_cfg_s'(cfg_b_reg[7:0])
		: task_cfg_s'(cfg_a_reg[7:0]);
	assign cur_scl  = active_b_reg ? scale_cfg_s'(scl_b_reg[28:0])
		: scale_cfg_s'(scl_a_reg[28:0]);
	assign other_en = active_b_reg ? en_a : en_b;
	assign cur_en   = active_b_reg ? en_b : en_a;
	assign running  = (state_reg == ST_RUN);

	// register bus: address and data taken in either order
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;
	assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= '0;
			w_strb_reg  <= '0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {s_axi_awaddr[ADDR_W-1:2], 2'h0};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= reg_known(aw_addr_reg) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// task setup takes effect as soon as the register write completes, even mid-task; enables are read only in idle and at task end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl_reg  <= CTRL_RST;
			cfg_a_reg <= CFG_RST;
			cfg_b_reg <= CFG_RST;
			scl_a_reg <= SCL_RST;
			scl_b_reg <= SCL_RST;
		end else if (wr_fire) begin
			unique case (aw_addr_reg)
				OFF_CTRL:  ctrl_reg  <= apply_wstrb(ctrl_reg, w_data_reg, w_strb_reg);
				OFF_CFG_A: cfg_a_reg <= apply_wstrb(cfg_a_reg, w_data_reg, w_strb_reg);
				OFF_CFG_B: cfg_b_reg <= apply_wstrb(cfg_b_reg, w_data_reg, w_strb_reg);
				OFF_SCL_A: scl_a_reg <= apply_wstrb(scl_a_reg, w_data_reg, w_strb_reg);
				OFF_SCL_B: scl_b_reg <= apply_wstrb(scl_b_reg, w_data_reg, w_strb_reg);
				default:   ;
			endcase
		end
	end

	assign stat_word = {24'h0, 1'b0, d7_reg, d6_reg, tog_reg,
		running, active_b_reg, state_reg != ST_IDLE};

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= '0;
			rresp_reg  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case ({s_axi_araddr[ADDR_W-1:2], 2'h0})
				OFF_CTRL:  rdata_reg <= ctrl_reg;
				OFF_CFG_A: rdata_reg <= cfg_a_reg;
				OFF_CFG_B: rdata_reg <= cfg_b_reg;
				OFF_SCL_A: rdata_reg <= scl_a_reg;
				OFF_SCL_B: rdata_reg <= scl_b_reg;
				OFF_STAT:  rdata_reg <= stat_word;
				default:   rdata_reg <= '0;
			endcase
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// pin synchronisers; third vsync stage only feeds the edge detect
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			vs_sync_reg  <= '0;
			fid_sync_reg <= '0;
		end else begin
			vs_sync_reg  <= {vs_sync_reg[1:0], vsync_pin};
			fid_sync_reg <= {fid_sync_reg[0], field_identity_pin};
		end
	end

	assign vs_rise = vs_sync_reg[1] && !vs_sync_reg[2];
	assign field_identity     = fid_sync_reg[1];

	// field condition only looked at on a vsync edge while waiting
	always_comb begin
		unique case (cur_cfg.start_condition_select)
			START_NOW:    trig_ok = 1'b1;
			START_VSYNC:  trig_ok = vs_rise;
			START_FIELD0: trig_ok = vs_rise && !field_identity;
			START_FIELD1: trig_ok = vs_rise && field_identity;
		endcase
	end

	// soft reset low parks the sequencer; release order sets field mapping
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_reg    <= ST_IDLE;
			active_b_reg <= 1'b1;
			repeated_reg <= 1'b0;
			skip_reg     <= '0;
		end else if (!soft_run) begin
			state_reg    <= ST_IDLE;
			active_b_reg <= 1'b1;
			repeated_reg <= 1'b0;
			skip_reg     <= '0;
		end else begin
			unique case (state_reg)
				ST_IDLE: if (en_a || en_b) begin
					active_b_reg <= en_b;
					state_reg    <= ST_TRIG;
				end
				ST_TRIG: if (trig_ok) begin
					skip_reg  <= cur_cfg.field_skip_count;
					state_reg <= (cur_cfg.field_skip_count == '0) ? ST_WIN : ST_SKIP;
				end
				ST_SKIP: if (vs_rise) begin
					skip_reg <= skip_reg - 1'b1;
					if (skip_reg == SKIP_LAST)
						state_reg <= ST_WIN;
				end
				ST_WIN: if (window_reached)
					state_reg <= ST_RUN;
				ST_RUN: if (task_done) begin
					if (cur_cfg.task_repeat && !repeated_reg) begin
						repeated_reg <= 1'b1;
						state_reg    <= ST_TRIG;
					end else begin
						repeated_reg <= 1'b0;
						if (other_en)
							active_b_reg <= !active_b_reg;
						state_reg <= (other_en || cur_en) ? ST_TRIG : ST_IDLE;
					end
				end
			endcase
		end
	end

	// one toggle per task, flipped at task start, blind to field identity
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tog_reg <= '0;
		end else if (!soft_run) begin
			tog_reg <= '0;
		end else if (state_reg == ST_WIN && window_reached) begin
			tog_reg[active_b_reg] <= !tog_reg[active_b_reg];
		end
	end

	assign d6_next = cur_cfg.output_field_id_select ? tog_reg[active_b_reg]
		: field_identity;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			d6_reg  <= 1'b0;
			d7_reg  <= 1'b1;
			gpa_reg <= 1'b0;
			gpb_reg <= 1'b0;
		end else begin
			d6_reg  <= d6_next;
			d7_reg  <= !cur_cfg.code_mark_invert;
			gpa_reg <= gp_pick(gp_sel_a, d6_next, cur_cfg.code_mark_invert, running);
			gpb_reg <= gp_pick(gp_sel_b, d6_next, cur_cfg.code_mark_invert, running);
		end
	end

	assign sav_eav_d6      = d6_reg;
	assign sav_eav_d7      = d7_reg;
	assign gp_output_pin_a = gpa_reg;
	assign gp_output_pin_b = gpb_reg;
	assign task_active     = running;
	assign active_task_b   = active_b_reg;

	hscaler #(.W(PIX_W)) u_hscaler (
		.mclk      (mclk),
		.rst       (rst),
		.clr       (!soft_run),
		.scl       (cur_scl),
		.in_valid  (pix_in_valid),
		.in_ready  (pix_in_ready),
		.in_data   (pix_in_data),
		.out_valid (pix_out_valid),
		.out_ready (pix_out_ready),
		.out_data  (pix_out_data)
	);

	chk_prio_after_reset: assert property (@(posedge mclk) disable iff (rst)
		state_reg == ST_IDLE && soft_run && en_b |=> active_b_reg && state_reg == ST_TRIG)
		else $error("task B not first after reset");

	chk_trig_ignored: assert property (@(posedge mclk) disable iff (rst)
		state_reg == ST_TRIG && soft_run && cur_cfg.start_condition_select != START_NOW
		&& !vs_rise |=> state_reg == ST_TRIG)
		else $error("task started without its trigger");

	chk_field_match: assert property (@(posedge mclk) disable iff (rst)
		state_reg == ST_TRIG && soft_run && vs_rise && !field_identity &&
		cur_cfg.start_condition_select == START_FIELD1 |=> state_reg == ST_TRIG)
		else $error("field 1 start taken on field 0");

	chk_toggle_flip: assert property (@(posedge mclk) disable iff (rst)
		state_reg == ST_WIN && window_reached && soft_run |=>
		(tog_reg ^ $past(tog_reg)) == (active_b_reg ? 2'h2 : 2'h1))
		else $error("toggle of started task did not flip");

	chk_d6_toggle: assert property (@(posedge mclk) disable iff (rst)
		state_reg == ST_WIN && window_reached && soft_run &&
		cur_cfg.output_field_id_select |-> ##2 d6_reg != $past(d6_reg))
		else $error("d6 did not follow task toggle");

	chk_d6_field: assert property (@(posedge mclk) disable iff (rst)
		!cur_cfg.output_field_id_select ##1 $stable(field_identity) |-> d6_reg == field_identity)
		else $error("d6 does not carry input field identity");

	chk_d7_mark: assert property (@(posedge mclk) disable iff (rst)
		##1 1'b1 |-> sav_eav_d7 == !$past(cur_cfg.code_mark_invert))
		else $error("d7 not set from code mark");

	chk_gp_task_flag: assert property (@(posedge mclk) disable iff (rst)
		gp_sel_a == GP_TASK |=> gp_output_pin_a == $past(cur_cfg.code_mark_invert))
		else $error("gp pin a not showing task flag");

	chk_repeat_once: assert property (@(posedge mclk) disable iff (rst)
		state_reg == ST_RUN && task_done && soft_run && cur_cfg.task_repeat &&
		!repeated_reg |=> $stable(active_b_reg) && state_reg == ST_TRIG)
		else $error("repeat did not rerun the task");

	chk_skip_hold: assert property (@(posedge mclk) disable iff (rst)
		state_reg == ST_SKIP && soft_run && !vs_rise |=>
		state_reg == ST_SKIP && $stable(skip_reg))
		else $error("skip count moved without a field");

endmodule : scaler_task_field_control

`default_nettype wire

// ==== scaler_task_field_control_tb_top.sv ====
// testbench for the scaler task sequencer and field marking
// assumes the sink model on the pixel output; bready/rready held high
`timescale 1ns/10ps
`default_nettype none

`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
	failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module scaler_task_field_control_tb_top;
	import scaler_pkg::*;
	logic        mclk = 0, rst = 1, vs = 0, field_identity = 0, win = 0, done = 0;
	logic [7:0]  awaddr = '0, araddr = '0, pin_d = '0, pod;
	logic [31:0] wdata = '0, rdata, rd;
	logic [1:0]  bresp, rresp, rsp;
	logic        awv = 0, awr, wv = 0, wr, bv, arv = 0, arr, rv;
	logic        piv = 0, pir, pov, por, d6, d7, gpa, gpb, tact, actb;
	int          failures = 0, num_checks = 0, cyc = 0;

	scaler_task_field_control dut (.mclk(mclk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
		.s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(1'b1), .vsync_pin(vs),
		.field_identity_pin(field_identity), .window_reached(win), .task_done(done),
		.pix_in_valid(piv), .pix_in_ready(pir), .pix_in_data(pin_d),
		.pix_out_valid(pov), .pix_out_ready(por), .pix_out_data(pod),
		.sav_eav_d6(d6), .sav_eav_d7(d7), .gp_output_pin_a(gpa),
		.gp_output_pin_b(gpb), .task_active(tact), .active_task_b(actb));

	scaler_sink_model sink (.mclk(mclk), .rst(rst), .pix_out_valid(pov),
		.pix_out_data(pod), .pix_out_ready(por));

	always #25 mclk = ~mclk;

	// whole run needs about 260 cycles; generous margin
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			failures++;
			conclude();
		end
	end

	always @(posedge mclk)
		if (piv && pir)
			pin_d <= pin_d + 8'h1;

	task automatic conclude();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		forever begin
			@(posedge mclk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
			if (bv) break;
		end
		rsp = bresp;
	endtask : wreg

	task automatic rreg(input logic [7:0] a);
		araddr <= a;
		arv <= 1'b1;
		forever begin
			@(posedge mclk);
			if (arv && arr) arv <= 1'b0;
			if (rv) break;
		end
		rd = rdata;
		rsp = rresp;
	endtask : rreg

	// field id, optional vsync pulse, then window until the task runs
	task automatic act(input logic f, input logic pulse);
		field_identity <= f;
		repeat (4) @(posedge mclk);
		vs <= pulse;
		repeat (4) @(posedge mclk);
		vs <= 1'b0;
		repeat (4) @(posedge mclk);
		win <= 1'b1;
		for (int i = 0; i < 12 && tact !== 1'b1; i++) @(posedge mclk);
		win <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : act

	task automatic fin();
		done <= 1'b1;
		@(posedge mclk);
		done <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : fin

	initial begin
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		piv <= 1'b1;
		rreg(OFF_CTRL);
		`CHK("ctrl", CTRL_RST, rd);
		rreg(OFF_SCL_A);
		`CHK("scl_a", SCL_RST, rd);
		rreg(8'h18);
		`CHK("unmapped", RESP_SLVERR, rsp);
		`CHK("d7_rst", 1'b1, d7);
		`CHK("b_rst", 1'b1, actb);
		wreg(8'h18, 32'h0000_0001);
		`CHK("wr_unmapped", RESP_SLVERR, rsp);
		wreg(OFF_SCL_B, 32'h012c_003f);
		`CHK("bresp", RESP_OKAY, rsp);
		rreg(OFF_SCL_B);
		`CHK("scl_b", 32'h012c_003f, rd);
		// descending modes so each waits before the next is armed
		for (int m = 3; m >= 0; m--) begin
			wreg(OFF_CFG_B, 32'hc0 | 32'(m));
			if (m == 3) wreg(OFF_CTRL, 32'h36);
			if (m != 0) begin
				act(m == 2, m != 1);
				`CHK("held", 1'b0, tact);
			end
			act(m == 3, 1'b1);
			`CHK("start", 1'b1, tact);
			`CHK("d6_tog", m[0], d6);
			`CHK("gp_b", m[0], gpb);
			`CHK("d7_mark", 1'b0, d7);
			`CHK("gp_a", 1'b1, gpa);
			rreg(OFF_STAT);
			`CHK("tog_b", m[0], rd[4]);
			fin();
		end
		wreg(OFF_CFG_A, 32'h0);
		wreg(OFF_CTRL, 32'h32);
		wreg(OFF_CTRL, 32'h37);
		act(1'b0, 1'b0);
		`CHK("b_first", 1'b1, actb);
		`CHK("d6_b", 1'b1, d6);
		fin();
		act(1'b0, 1'b0);
		`CHK("a_next", 1'b0, actb);
		`CHK("d6_fid", 1'b0, d6);
		`CHK("d7_a", 1'b1, d7);
		`CHK("gp_a0", 1'b0, gpa);
		fin();
		`CHK("pixels", 1'b1, sink.beats > 0);
		`CHK("first_pix", 1'b1, sink.got_first);
		`CHK("first_pix_val", 8'h00, sink.first_data);
		conclude();
	end
endmodule : scaler_task_field_control_tb_top

`default_nettype wire
